// *** rtl/ddr2_cmd_pkg.sv ***
package ddr2_cmd_pkg;

   // Command decode values of {ras_b, cas_b, we_b} with cs_b low.
   localparam logic [2:0] CMD_NOP       = 3'h7;
   localparam logic [2:0] CMD_ACTIVE    = 3'h3;
   localparam logic [2:0] CMD_READ      = 3'h5;
   localparam logic [2:0] CMD_WRITE     = 3'h4;
   localparam logic [2:0] CMD_PRECHARGE = 3'h2;
   localparam logic [2:0] CMD_MODE      = 3'h0;

   // Mode register selection on the bank pins.
   localparam logic [1:0] MR_BASE  = 2'h0;
   localparam logic [1:0] MR_EXT1  = 2'h1;
   localparam logic [1:0] MR_EXT3  = 2'h3;

   // Field positions.
   localparam int CL_LSB   = 4;
   localparam int AL_LSB   = 3;
   localparam int CAL_LSB  = 7;
   localparam int AP_BIT   = 10;

   // Calibration control codes.
   typedef enum logic [2:0] {
      CAL_EXIT    = 3'h0,
      CAL_DRIVE1  = 3'h1,
      CAL_DRIVE0  = 3'h2,
      CAL_ADJUST  = 3'h4,
      CAL_DEFAULT = 3'h7
   } cal_mode_t;

   // Reset values, step limit and burst length.
   localparam logic [3:0] STEP_RESET = 4'h8;
   localparam logic [3:0] STEP_MAX   = 4'hf;
   localparam logic [2:0] CL_RESET   = 3'h3;
   localparam logic [2:0] AL_RESET   = 3'h0;
   localparam int         BURST_BEATS = 4;

endpackage

// *** rtl/step_counter.sv ***
`timescale 1ns/1ps

module step_counter (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       load_default,
   input  wire logic       inc,
   input  wire logic       dec,
   output logic [3:0]      step_r
);

   // Saturating step counter, limits stop further steps.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step_r <= ddr2_cmd_pkg::STEP_RESET;
      end else if (load_default) begin
         step_r <= ddr2_cmd_pkg::STEP_RESET;
      end else if (inc && (step_r != ddr2_cmd_pkg::STEP_MAX)) begin
         step_r <= step_r + 4'h1;
      end else if (dec && (step_r != 4'h0)) begin
         step_r <= step_r - 4'h1;
      end
   end

endmodule

// *** rtl/ddr2_bank_command_ocd_control.sv ***
`timescale 1ns/1ps

module ddr2_bank_command_ocd_control #(
   parameter int DQ_W  = 16,
   parameter int ROW_W = 13,
   parameter int LAT_W = 5
) (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              link_clk,
   input  wire logic              cs_b,
   input  wire logic              ras_b,
   input  wire logic              cas_b,
   input  wire logic              we_b,
   input  wire logic [1:0]        bank_sel,
   input  wire logic [ROW_W-1:0]  addr,
   input  wire logic [DQ_W-1:0]   dq_in,
   input  wire logic              term_pin,
   input  wire logic              self_refresh,
   output logic [3:0]             bank_open_r,
   output logic [3:0]             pull_up_r,
   output logic [3:0]             pull_down_r,
   output logic [2:0]             cal_mode_r,
   output logic [LAT_W-1:0]       read_lat_r,
   output logic [LAT_W-1:0]       write_lat_r,
   output logic                   rd_exec_r,
   output logic                   wr_exec_r,
   output logic [1:0]             exec_bank_r,
   output logic [DQ_W-1:0]        dq_out_r,
   output logic [DQ_W-1:0]        dq_oe_r,
   output logic [1:0]             dqs_out_r,
   output logic [1:0]             dqs_b_out_r,
   output logic                   dqs_oe_r,
   output logic                   term_en_r,
   output logic                   ext3_bad_r
);

   // Link-domain state: command taken straight from the pins and decoded strobes.
   logic [2:0]  cmd;
   logic        sel;
   logic        is_pre;
   logic        is_act;
   logic        is_rd;
   logic        is_wr;
   logic        is_mode;
   logic [2:0]  cl_r;
   logic [2:0]  al_r;
   logic [7:0]  rd_pipe_r;
   logic [7:0]  wr_pipe_r;
   logic [1:0]  bank_pipe_r [8];
   logic [1:0]  beat_r;
   logic [2:0]  code_r;
   logic        adj_busy_r;
   logic        adj_tog_r;
   logic [3:0]  adj_code_r;
   logic        dflt_tog_r;
   logic [2:0]  mode_lk_r;
   logic [2:0]  beats_r;

   // Core-domain crossing state.
   logic [2:0]  adj_sync_r;
   logic [2:0]  dflt_sync_r;
   logic [2:0]  mode_s1_r;
   logic [2:0]  mode_s2_r;
   logic [2:0]  mode_s3_r;
   logic [1:0]  term_sync_r;
   logic [1:0]  sr_sync_r;
   logic [3:0]  up_step;
   logic [3:0]  dn_step;
   logic        up_inc;
   logic        up_dec;
   logic        dn_inc;
   logic        dn_dec;
   logic        adj_evt;
   logic        dflt_evt;
   logic        drive_hi;
   logic        drive_lo;

   // Combinational command decode of the link pins.
   assign cmd     = {ras_b, cas_b, we_b};
   assign sel     = !cs_b;
   assign is_pre  = sel && (cmd == ddr2_cmd_pkg::CMD_PRECHARGE);
   assign is_act  = sel && (cmd == ddr2_cmd_pkg::CMD_ACTIVE);
   assign is_rd   = sel && (cmd == ddr2_cmd_pkg::CMD_READ);
   assign is_wr   = sel && (cmd == ddr2_cmd_pkg::CMD_WRITE);
   assign is_mode = sel && (cmd == ddr2_cmd_pkg::CMD_MODE);

   // Bank open state; NOP leaves banks as they are.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         bank_open_r <= 4'h0;
      end else if (is_act) begin
         bank_open_r[bank_sel] <= 1'b1;
      end else if (is_pre) begin
         if (addr[ddr2_cmd_pkg::AP_BIT]) begin
            bank_open_r <= 4'h0;
         end else begin
            bank_open_r[bank_sel] <= 1'b0;
         end
      end
   end

   // Mode register writes: latencies, calibration field, reserved check.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         cl_r       <= ddr2_cmd_pkg::CL_RESET;
         al_r       <= ddr2_cmd_pkg::AL_RESET;
         code_r     <= ddr2_cmd_pkg::CAL_EXIT;
         ext3_bad_r <= 1'b0;
      end else if (is_mode) begin
         if (bank_sel == ddr2_cmd_pkg::MR_BASE) begin
            cl_r <= addr[ddr2_cmd_pkg::CL_LSB +: 3];
         end
         if (bank_sel == ddr2_cmd_pkg::MR_EXT1) begin
            al_r   <= addr[ddr2_cmd_pkg::AL_LSB +: 3];
            code_r <= addr[ddr2_cmd_pkg::CAL_LSB +: 3];
         end
         if (bank_sel == ddr2_cmd_pkg::MR_EXT3) begin
            ext3_bad_r <= (addr != '0);
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         read_lat_r  <= '0;
         write_lat_r <= '0;
      end else begin
         read_lat_r  <= LAT_W'(al_r) + LAT_W'(cl_r);
         write_lat_r <= LAT_W'(al_r) + LAT_W'(cl_r) - LAT_W'(1);
      end
   end

   // Posted command delay line, tap chosen by additive latency.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_pipe_r <= 8'h00;
         wr_pipe_r <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            bank_pipe_r[i] <= 2'h0;
         end
      end else begin
         rd_pipe_r <= {rd_pipe_r[6:0], is_rd};
         wr_pipe_r <= {wr_pipe_r[6:0], is_wr};
         bank_pipe_r[0] <= bank_sel;
         for (int i = 1; i < 8; i++) begin
            bank_pipe_r[i] <= bank_pipe_r[i-1];
         end
      end
   end

   // Internal execute strobes after additive latency; AL 0 is one stage.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_exec_r   <= 1'b0;
         wr_exec_r   <= 1'b0;
         exec_bank_r <= 2'h0;
      end else if (al_r == 3'h0) begin
         rd_exec_r   <= is_rd;
         wr_exec_r   <= is_wr;
         exec_bank_r <= bank_sel;
      end else begin
         rd_exec_r   <= rd_pipe_r[al_r - 3'h1];
         wr_exec_r   <= wr_pipe_r[al_r - 3'h1];
         exec_bank_r <= bank_pipe_r[al_r - 3'h1];
      end
   end

   // Collect four DQ beats after a write command in adjust mode.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         adj_busy_r <= 1'b0;
         beat_r     <= 2'h0;
         beats_r    <= 3'h0;
         adj_code_r <= 4'h0;
         adj_tog_r  <= 1'b0;
      end else if (is_wr && (code_r == ddr2_cmd_pkg::CAL_ADJUST)) begin
         adj_busy_r <= 1'b1;
         beat_r     <= 2'h0;
      end else if (adj_busy_r) begin
         // Data bit 0 stands for every lane, all driven alike.
         beats_r <= {dq_in[0], beats_r[2:1]};
         beat_r <= beat_r + 2'h1;
         if (beat_r == 2'(ddr2_cmd_pkg::BURST_BEATS - 1)) begin
            adj_busy_r <= 1'b0;
            adj_code_r <= {dq_in[0], beats_r};
            adj_tog_r  <= !adj_tog_r;
         end
      end
   end

   // Default restore event and calibration mode, carried as toggle and bus.
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         dflt_tog_r <= 1'b0;
         mode_lk_r  <= ddr2_cmd_pkg::CAL_EXIT;
      end else begin
         mode_lk_r <= code_r;
         if (is_mode && (bank_sel == ddr2_cmd_pkg::MR_EXT1) &&
             (addr[ddr2_cmd_pkg::CAL_LSB +: 3] ==
              ddr2_cmd_pkg::CAL_DEFAULT)) begin
            dflt_tog_r <= !dflt_tog_r;
         end
      end
   end

   // Crossings into the core clock domain.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         adj_sync_r  <= 3'h0;
         dflt_sync_r <= 3'h0;
         mode_s1_r   <= 3'h0;
         mode_s2_r   <= 3'h0;
         mode_s3_r   <= 3'h0;
         term_sync_r <= 2'h0;
         sr_sync_r   <= 2'h0;
      end else begin
         adj_sync_r  <= {adj_sync_r[1:0], adj_tog_r};
         dflt_sync_r <= {dflt_sync_r[1:0], dflt_tog_r};
         mode_s1_r   <= mode_lk_r;
         mode_s2_r   <= mode_s1_r;
         mode_s3_r   <= mode_s2_r;
         term_sync_r <= {term_sync_r[0], term_pin};
         sr_sync_r   <= {sr_sync_r[0], self_refresh};
      end
   end

   assign adj_evt  = adj_sync_r[2] ^ adj_sync_r[1];
   assign dflt_evt = dflt_sync_r[2] ^ dflt_sync_r[1];

   always_comb begin
      up_inc = 1'b0;
      up_dec = 1'b0;
      dn_inc = 1'b0;
      dn_dec = 1'b0;
      if (adj_evt) begin
         unique case (adj_code_r)
            4'h8:    up_inc = 1'b1;
            4'h4:    up_dec = 1'b1;
            4'h2:    dn_inc = 1'b1;
            4'h1:    dn_dec = 1'b1;
            4'ha: begin
               up_inc = 1'b1;
               dn_inc = 1'b1;
            end
            4'h6: begin
               up_dec = 1'b1;
               dn_inc = 1'b1;
            end
            4'h9: begin
               up_inc = 1'b1;
               dn_dec = 1'b1;
            end
            4'h5: begin
               up_dec = 1'b1;
               dn_dec = 1'b1;
            end
            default: ;
         endcase
      end
   end

   step_counter u_pull_up (
      .clk          (mclk),
      .rst_b        (rst_b),
      .load_default (dflt_evt),
      .inc          (up_inc),
      .dec          (up_dec),
      .step_r       (up_step)
   );

   step_counter u_pull_down (
      .clk          (mclk),
      .rst_b        (rst_b),
      .load_default (dflt_evt),
      .inc          (dn_inc),
      .dec          (dn_dec),
      .step_r       (dn_step)
   );

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pull_up_r   <= ddr2_cmd_pkg::STEP_RESET;
         pull_down_r <= ddr2_cmd_pkg::STEP_RESET;
         cal_mode_r  <= ddr2_cmd_pkg::CAL_EXIT;
      end else begin
         pull_up_r   <= up_step;
         pull_down_r <= dn_step;
         // A code caught mid-change never shows in two samples running.
         if (mode_s2_r == mode_s3_r) begin
            cal_mode_r <= mode_s3_r;
         end
      end
   end

   assign drive_hi = (cal_mode_r == ddr2_cmd_pkg::CAL_DRIVE1);
   assign drive_lo = (cal_mode_r == ddr2_cmd_pkg::CAL_DRIVE0);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dq_out_r    <= '0;
         dq_oe_r     <= '0;
         dqs_out_r   <= 2'h0;
         dqs_b_out_r <= 2'h0;
         dqs_oe_r    <= 1'b0;
      end else begin
         dq_out_r    <= {DQ_W{drive_hi}};
         dq_oe_r     <= {DQ_W{drive_hi || drive_lo}};
         dqs_out_r   <= {2{drive_hi}};
         dqs_b_out_r <= {2{drive_lo}};
         dqs_oe_r    <= drive_hi || drive_lo;
      end
   end

   // Termination gated off in self refresh.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         term_en_r <= 1'b0;
      end else begin
         term_en_r <= term_sync_r[1] && !sr_sync_r[1];
      end
   end

endmodule

// *** verification/ddr2_ocd_checker_assertions.sv ***
`timescale 1ns/1ps
// Checks decode, latency, calibration and termination at the ports.
module ddr2_ocd_checker #(
   parameter int DQ_W  = 16,
   parameter int ROW_W = 13,
   parameter int LAT_W = 5
) (
   input wire logic             mclk,
   input wire logic             rst_b,
   input wire logic             link_clk,
   input wire logic             cs_b,
   input wire logic             ras_b,
   input wire logic             cas_b,
   input wire logic             we_b,
   input wire logic [1:0]       bank_sel,
   input wire logic [ROW_W-1:0] addr,
   input wire logic             self_refresh,
   input wire logic [3:0]       bank_open_r,
   input wire logic [3:0]       pull_up_r,
   input wire logic [2:0]       cal_mode_r,
   input wire logic [LAT_W-1:0] read_lat_r,
   input wire logic [LAT_W-1:0] write_lat_r,
   input wire logic [DQ_W-1:0]  dq_out_r,
   input wire logic [1:0]       dqs_out_r,
   input wire logic             term_en_r,
   input wire logic             ext3_bad_r
);
   // Commands as seen at the link pins.
   sequence act_s;
      !cs_b && {ras_b, cas_b, we_b} == ddr2_cmd_pkg::CMD_ACTIVE;
   endsequence
   sequence pre_s;
      !cs_b && {ras_b, cas_b, we_b} == ddr2_cmd_pkg::CMD_PRECHARGE;
   endsequence
   sequence ext3_s;
      !cs_b && {ras_b, cas_b, we_b} == ddr2_cmd_pkg::CMD_MODE &&
      bank_sel == ddr2_cmd_pkg::MR_EXT3;
   endsequence
   AST_ACT_OPEN: assert property (
      @(posedge link_clk) disable iff (!rst_b) act_s |=> bank_open_r ==
      ($past(bank_open_r) | (4'h1 << $past(bank_sel))))
      else $error("activate did not open only its bank");
   AST_PRE_ONE: assert property (
      @(posedge link_clk) disable iff (!rst_b) pre_s ##0 !addr[10] |=>
      bank_open_r == ($past(bank_open_r) & ~(4'h1 << $past(bank_sel))))
      else $error("single precharge closed the wrong banks");
   AST_PRE_ALL: assert property (
      @(posedge link_clk) disable iff (!rst_b)
      pre_s ##0 addr[10] |=> bank_open_r == 4'h0)
      else $error("precharge all left a bank open");
   AST_EXT3: assert property (
      @(posedge link_clk) disable iff (!rst_b)
      ext3_s |=> ext3_bad_r == ($past(addr) != '0))
      else $error("reserved register flag wrong");
   AST_LAT: assert property (
      @(posedge link_clk) disable iff (!rst_b)
      read_lat_r != '0 |-> write_lat_r == read_lat_r - 1'b1)
      else $error("write latency not read latency minus one");
   AST_STEP: assert property (
      @(posedge mclk) disable iff (!rst_b) $changed(pull_up_r) |->
      pull_up_r == ddr2_cmd_pkg::STEP_RESET || pull_up_r ==
      $past(pull_up_r) + 5'h1 || pull_up_r == $past(pull_up_r) - 5'h1)
      else $error("pull-up step jumped");
   AST_DRIVE1: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (cal_mode_r == ddr2_cmd_pkg::CAL_DRIVE1) [*3] |->
      &dq_out_r && dqs_out_r == 2'h3)
      else $error("drive-high mode not driving high");
   AST_TERM_OFF: assert property (
      @(posedge mclk) disable iff (!rst_b)
      self_refresh [*4] |-> !term_en_r)
      else $error("termination on in self refresh");
endmodule
bind ddr2_bank_command_ocd_control ddr2_ocd_checker #(
   .DQ_W(DQ_W), .ROW_W(ROW_W), .LAT_W(LAT_W)) chk_u (.*);

// *** verification/mem_ctrl_model.sv ***
`timescale 1ns/1ps
// Controller model driving command, address and data pins.
module mem_ctrl_model (
   input  wire logic   link_clk,
   output logic        cs_b,
   output logic        ras_b,
   output logic        cas_b,
   output logic        we_b,
   output logic [1:0]  bank_sel,
   output logic [12:0] addr,
   output logic [15:0] dq_in
);
   // Pins start deselected.
   initial begin
      {cs_b, ras_b, cas_b, we_b, bank_sel, addr} = '1;
      dq_in = 16'h0000;
   end
   function automatic logic [12:0] ext1(input logic [2:0] al,
                                        input logic [2:0] cal);
      return (13'(al) << ddr2_cmd_pkg::AL_LSB) |
             (13'(cal) << ddr2_cmd_pkg::CAL_LSB);
   endfunction
   // Holds a command for one cycle, then deselects with inverted pins.
   // command encoding.
   task automatic issue(input logic [2:0] c, input logic [1:0] ba,
                        input logic [12:0] a);
      @(negedge link_clk);
      {cs_b, ras_b, cas_b, we_b, bank_sel, addr} <= {1'b0, c, ba, a};
      @(negedge link_clk);
      {cs_b, ras_b, cas_b, we_b, bank_sel, addr} <= {1'b1, ~c, ~ba, ~a};
   endtask
   // Adjust mode, a write command, then the code on every line, DT0 first.
   // burst then exit.
   task automatic adjust(input logic [3:0] code, input logic [2:0] al);
      issue(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::MR_EXT1,
            ext1(al, ddr2_cmd_pkg::CAL_ADJUST));
      issue(ddr2_cmd_pkg::CMD_WRITE, 2'h0, 13'h0000);
      for (int i = 3; i >= 0; i--) begin
         dq_in <= {16{code[i]}};
         @(negedge link_clk);
      end
      dq_in <= ~dq_in;
      issue(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::MR_EXT1,
            ext1(al, ddr2_cmd_pkg::CAL_EXIT));
   endtask
endmodule

// *** verification/ddr2_bank_command_ocd_control_bench.sv ***
`timescale 1ns/1ps
// Bench: drives the device through the controller model.
module ddr2_bank_command_ocd_control_bench;
   logic        mclk;
   logic        link_clk;
   logic        rst_b;
   logic        term_pin;
   logic        self_refresh;
   logic        cs_b, ras_b, cas_b, we_b;
   logic [1:0]  bank_sel, exec_bank_r, dqs_out_r, dqs_b_out_r;
   logic [12:0] addr;
   logic [15:0] dq_in, dq_out_r, dq_oe_r, rnd;
   logic [3:0]  bank_open_r, pull_up_r, pull_down_r, code, mask;
   logic [4:0]  read_lat_r, write_lat_r;
   logic [2:0]  cal_mode_r;
   logic        rd_exec_r, wr_exec_r, dqs_oe_r, term_en_r, ext3_bad_r;
   int          fails, checks_done, pu, pd, al, cl, k;
   ddr2_bank_command_ocd_control dut_u (.*);
   mem_ctrl_model pm_u (.*);
   // Core clock, 25 ns.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Link clock, 80 ns, offset from the core clock.
   initial begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int sat(input int v);
      return v < 0 ? 0 : (v > 15 ? 15 : v);
   endfunction
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic settle;
      repeat (4) @(negedge link_clk);
   endtask
   task automatic emr1(input logic [2:0] cal);
      pm_u.issue(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::MR_EXT1,
                 pm_u.ext1(3'(al), cal));
      settle;
   endtask
   // Column command, then counts link cycles to its execution pulse.
   task automatic col(input logic [2:0] c, input logic [1:0] ba);
      pm_u.issue(c, ba, 13'h0000);
      for (k = 0; k < 9 && (rd_exec_r | wr_exec_r) !== 1'b1; k++) begin
         @(posedge link_clk);
         #1;
      end
      check("exec", {k[3:0], exec_bank_r, rd_exec_r, wr_exec_r},
            {4'(al), ba, c[0], !c[0]});
   endtask
   // Watchdog against a hang.
   initial begin
      #400us;
      fails++;
      tally_and_finish;
   end
   initial begin
      {rst_b, term_pin, self_refresh} = 3'h0;
      rnd = 16'h3c93;
      pu = 8;
      pd = 8;
      repeat (5) @(negedge mclk);
      rst_b = 1'b1;
      check("rst", {pull_up_r, pull_down_r, bank_open_r}, 16'h880);
      // Latencies and posted column commands for additive latency 0, 2.
      for (int n = 0; n < 2; n++) begin
         al = 2 * n;
         cl = 4 + n;
         pm_u.issue(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::MR_BASE,
                    13'(cl << ddr2_cmd_pkg::CL_LSB));
         emr1(ddr2_cmd_pkg::CAL_EXIT);
         check("rl", read_lat_r, 16'(al + cl));
         check("wl", write_lat_r, 16'(al + cl - 1));
         rnd = lfsr(rnd);
         pm_u.issue(ddr2_cmd_pkg::CMD_ACTIVE, rnd[1:0], 13'h0000);
         col(ddr2_cmd_pkg::CMD_READ, rnd[1:0]);
         col(ddr2_cmd_pkg::CMD_WRITE, rnd[1:0]);
         check("open", bank_open_r, 16'(4'h1 << rnd[1:0]));
         pm_u.issue(ddr2_cmd_pkg::CMD_PRECHARGE, rnd[1:0], 13'h0000);
      end
      // Open every bank, close each alone, then precharge all.
      mask = 4'hf;
      for (int b = 0; b < 4; b++) begin
         pm_u.issue(ddr2_cmd_pkg::CMD_ACTIVE, 2'(b), 13'h0000);
      end
      for (int b = 0; b < 4; b++) begin
         check("open", bank_open_r, 16'(mask));
         pm_u.issue(ddr2_cmd_pkg::CMD_PRECHARGE, 2'(b), 13'h0000);
         mask[b] = 1'b0;
      end
      check("open", bank_open_r, 16'h0);
      pm_u.issue(ddr2_cmd_pkg::CMD_ACTIVE, rnd[3:2], 13'h0000);
      pm_u.issue(ddr2_cmd_pkg::CMD_PRECHARGE, ~rnd[3:2], 13'h0400);
      check("all", bank_open_r, 16'h0);
      // Reserved register written with zero, nonzero, zero.
      for (int n = 0; n < 3; n++) begin
         rnd = lfsr(rnd);
         pm_u.issue(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::MR_EXT3,
                    n == 1 ? rnd[12:0] | 13'h1 : 13'h0000);
         check("ext3", ext3_bad_r, 16'(n == 1));
      end
      // Drive-high, exit, drive-low, exit: each mode closed by exit.
      for (int n = 1; n < 5; n++) begin
         code = n[0] ? 4'((n + 1) / 2) : 4'h0;
         emr1(code[2:0]);
         check("mode", cal_mode_r, 16'(code));
         check("dq", dq_out_r, code == 4'h1 ? 16'hffff : 16'h0);
         check("dqoe", dq_oe_r, code == 4'h0 ? 16'h0 : 16'hffff);
         check("dqs", {dqs_oe_r, dqs_out_r, dqs_b_out_r},
               code == 4'h1 ? 16'h1c : (code == 4'h2 ? 16'h13 : 16'h0));
      end
      // Bursts saturate up, then down, then random codes.
      for (int n = 0; n < 40; n++) begin
         rnd = lfsr(rnd);
         code = n < 10 ? 4'h5 : (n < 28 ? 4'ha : rnd[3:0]);
         pm_u.adjust(code, 3'(al));
         if (code[1:0] != 2'h3 && code[3:2] != 2'h3) begin
            pu = sat(pu + int'(code[0]) - int'(code[1]));
            pd = sat(pd + int'(code[2]) - int'(code[3]));
         end
         settle;
         check("up", pull_up_r, 16'(pu));
         check("down", pull_down_r, 16'(pd));
      end
      emr1(ddr2_cmd_pkg::CAL_DEFAULT);
      check("dflt", {pull_up_r, pull_down_r}, 16'h88);
      emr1(ddr2_cmd_pkg::CAL_EXIT);
      // Termination pin and self refresh in all four combinations.
      for (int n = 0; n < 4; n++) begin
         @(negedge mclk);
         {term_pin, self_refresh} = 2'(n);
         repeat (6) @(negedge mclk);
         check("term", term_en_r, 16'(n == 2));
      end
      tally_and_finish;
   end
endmodule
